// ---- rac_params.svh ----
// register map, field positions, reset values and frame counts of the amplifier control bank
`ifndef RAC_PARAMS_SVH
`define RAC_PARAMS_SVH

// channel window bases, one per amplifier channel
`define RAC_BASE_CH0      15'h0000
`define RAC_BASE_CH1      15'h0080
`define RAC_BASE_CH2      15'h0100
`define RAC_BASE_CH3      15'h0180

// word offsets inside a channel window
`define RAC_OFF_MAKER     5'h00
`define RAC_OFF_RSVD_A    5'h01
`define RAC_OFF_PART      5'h02
`define RAC_OFF_RSVD_B    5'h03
`define RAC_OFF_DATE      5'h04
`define RAC_OFF_SOFT_RST  5'h05
`define RAC_OFF_SQUELCH   5'h06
`define RAC_OFF_GAIN_MODE 5'h07
`define RAC_OFF_MONITOR   5'h08

// field positions
`define RAC_BIT_SOFT_RST  0
`define RAC_BIT_SQUELCH   0
`define RAC_BIT_AUTO_GAIN 0
`define RAC_BIT_SERIAL    1
`define RAC_BIT_PEAK_DET  10
`define RAC_BIT_GAIN_VOLT 9

// reset values
`define RAC_RST_SOFT_RST  1'h0
`define RAC_RST_SQUELCH   1'h1
`define RAC_RST_AUTO_GAIN 1'h0
`define RAC_RST_SERIAL    1'h0
`define RAC_RST_MONITOR   2'h0

// serial frame: 15 address bits, read flag, write flag, 16 data bits
`define RAC_HDR_LAST      6'h10
`define RAC_FRAME_LAST    6'h20

`endif

// ---- rac_pkg.sv ----
// types shared by the amplifier control bank
package rac_pkg;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_HDR,
		ST_DATA,
		ST_DONE
	} rac_state_type;

	typedef struct packed {
		logic [14:0] addr;
		logic        rd;
		logic        wr;
	} rac_cmd_type;

	typedef struct packed {
		logic       hit;
		logic [1:0] ch;
		logic [4:0] off;
	} rac_dec_type;

	typedef struct packed {
		logic hold_reset;
		logic squelch;
		logic auto_gain;
		logic serial_source;
	} rac_ctrl_type;

	typedef struct packed {
		logic peak_det;
		logic gain_volt;
	} rac_mon_type;

endpackage : rac_pkg

// ---- rac_sync.sv ----
// three-flop pin synchroniser whose level changes only when the last two flops agree
`timescale 1ns/1ps
module rac_sync #(
	parameter logic RESET_VAL = 1'h0
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic reset_n,
	// pin side
	input  wire logic async_in,
	// clock side
	output logic      level_q
);

	logic ff1_q;
	logic ff2_q;
	logic ff3_q;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ff1_q <= RESET_VAL;
			ff2_q <= RESET_VAL;
			ff3_q <= RESET_VAL;
		end else begin
			ff1_q <= async_in;
			ff2_q <= ff1_q;
			ff3_q <= ff2_q;
		end
	end

	// a one-cycle glitch on the pin never reaches the level
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			level_q <= RESET_VAL;
		end else if (ff2_q == ff3_q) begin
			level_q <= ff3_q;
		end
	end

endmodule : rac_sync

// ---- rac_mon_reg.sv ----
// monitor source selection word of one amplifier channel
`timescale 1ns/1ps
`include "rac_params.svh"
module rac_mon_reg (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// control
	input  wire logic        hold_reset,
	input  wire logic        wr_en,
	input  rac_pkg::rac_mon_type wr_val,
	// monitor selection
	output rac_pkg::rac_mon_type mon_q
);

	// off by default so that nothing drives the monitor pin until asked
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			mon_q <= `RAC_RST_MONITOR;
		end else if (hold_reset) begin
			mon_q <= `RAC_RST_MONITOR;
		end else if (wr_en) begin
			mon_q <= wr_val;
		end
	end

endmodule : rac_mon_reg

// ---- rac_ctrl_regs.sv ----
// serial register bank of the four-channel receiver amplifier
`timescale 1ns/1ps
`include "rac_params.svh"
module rac_ctrl_regs #(
	parameter logic [15:0] MAKER_ID = 16'h5A5A, // arbitrary value
	parameter logic [15:0] PART_ID  = 16'h0101, // arbitrary value
	parameter logic [15:0] DATE_REV = 16'h0001  // arbitrary value
) (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               reset_n,
	// serial pins
	input  wire logic               spi_clk_pin,
	input  wire logic               spi_csn_pin,
	input  wire logic               spi_mosi_pin,
	output logic                    spi_miso_o,
	output logic                    spi_miso_oe_n,
	// shared amplifier controls
	output rac_pkg::rac_ctrl_type   ctrl_q,
	// per-channel monitor selection, index is the channel
	output rac_pkg::rac_mon_type [3:0] mon_q
);

	localparam logic [3:0][14:0] CH_BASE = {`RAC_BASE_CH3, `RAC_BASE_CH2, `RAC_BASE_CH1, `RAC_BASE_CH0};

	logic                  sclk_f;
	logic                  csn_f;
	logic                  mosi_f;
	logic                  sclk_prev_q;
	logic                  rise;
	logic                  fall;
	rac_pkg::rac_state_type state_q;
	logic [5:0]            cnt_q;
	logic [16:0]           shift_q;
	rac_pkg::rac_cmd_type  cmd_q;
	rac_pkg::rac_cmd_type  cmd_d;
	logic [15:0]           tx_q;
	logic [15:0]           rd_word;
	logic [15:0]           wr_data;
	rac_pkg::rac_dec_type  rd_dec;
	rac_pkg::rac_dec_type  wr_dec;
	logic                  hdr_done;
	logic                  wr_fire;
	logic                  wr_shared;

	// pins come from the host's clock; each passes a three-flop synchroniser
	rac_sync #(.RESET_VAL(1'h0)) u_sync_sclk (
		.clk      (clk),
		.reset_n  (reset_n),
		.async_in (spi_clk_pin),
		.level_q  (sclk_f)
	);

	rac_sync #(.RESET_VAL(1'h1)) u_sync_csn (
		.clk      (clk),
		.reset_n  (reset_n),
		.async_in (spi_csn_pin),
		.level_q  (csn_f)
	);

	rac_sync #(.RESET_VAL(1'h0)) u_sync_mosi (
		.clk      (clk),
		.reset_n  (reset_n),
		.async_in (spi_mosi_pin),
		.level_q  (mosi_f)
	);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sclk_prev_q <= 1'h0;
		end else begin
			sclk_prev_q <= sclk_f;
		end
	end

	// data is taken on the leading edge and changed on the trailing edge
	assign rise = sclk_f & ~sclk_prev_q & ~csn_f;
	assign fall = ~sclk_f & sclk_prev_q & ~csn_f;

	// window decode: the upper address bits must match one channel base exactly
	function automatic rac_pkg::rac_dec_type decode(input logic [14:0] addr);
		rac_pkg::rac_dec_type d;
		d = '0;
		d.off = addr[4:0];
		for (int k = 0; k < 4; k++) begin
			if (addr[14:5] == CH_BASE[k][14:5]) begin
				d.hit = 1'h1;
				d.ch  = 2'(k);
			end
		end
		return d;
	endfunction : decode

	// frame sequencer
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= rac_pkg::ST_IDLE;
			cnt_q   <= 6'h00;
		end else if (csn_f) begin
			state_q <= rac_pkg::ST_IDLE;
			cnt_q   <= 6'h00;
		end else begin
			case (state_q)
				rac_pkg::ST_IDLE: begin
					state_q <= rac_pkg::ST_HDR;
					cnt_q   <= 6'h00;
				end
				rac_pkg::ST_HDR: begin
					if (rise) begin
						cnt_q <= cnt_q + 6'h01;
						if (cnt_q == `RAC_HDR_LAST) begin
							state_q <= rac_pkg::ST_DATA;
						end
					end
				end
				rac_pkg::ST_DATA: begin
					if (rise) begin
						cnt_q <= cnt_q + 6'h01;
						if (cnt_q == `RAC_FRAME_LAST) begin
							state_q <= rac_pkg::ST_DONE;
						end
					end
				end
				rac_pkg::ST_DONE: begin
					// clocks beyond the frame are ignored until chip select rises
					state_q <= rac_pkg::ST_DONE;
				end
				default: begin
					state_q <= rac_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// msb-first shift register shared by header and data
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			shift_q <= 17'h00000;
		end else if (rise && (state_q == rac_pkg::ST_HDR || state_q == rac_pkg::ST_DATA)) begin
			shift_q <= {shift_q[15:0], mosi_f};
		end
	end

	assign hdr_done = rise && state_q == rac_pkg::ST_HDR && cnt_q == `RAC_HDR_LAST;
	assign cmd_d    = rac_pkg::rac_cmd_type'({shift_q[15:0], mosi_f});
	assign rd_dec   = decode(cmd_d.addr);
	assign wr_dec   = decode(cmd_q.addr);
	assign wr_data  = {shift_q[14:0], mosi_f};

	// a write lands only once all sixteen data bits are in; a cut frame changes nothing
	assign wr_fire   = rise && state_q == rac_pkg::ST_DATA && cnt_q == `RAC_FRAME_LAST
	                   && cmd_q.wr && !cmd_q.rd && wr_dec.hit;
	assign wr_shared = wr_fire && wr_dec.ch == 2'h0;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cmd_q <= '0;
		end else if (hdr_done) begin
			cmd_q <= cmd_d;
		end
	end

	// read multiplexer; shared words answer only through channel zero
	always_comb begin
		rd_word = 16'h0000;
		if (rd_dec.hit) begin
			case (rd_dec.off)
				`RAC_OFF_MAKER: begin
					if (rd_dec.ch == 2'h0) rd_word = MAKER_ID;
				end
				`RAC_OFF_PART: begin
					if (rd_dec.ch == 2'h0) rd_word = PART_ID;
				end
				`RAC_OFF_DATE: begin
					if (rd_dec.ch == 2'h0) rd_word = DATE_REV;
				end
				`RAC_OFF_SOFT_RST: begin
					if (rd_dec.ch == 2'h0) rd_word[`RAC_BIT_SOFT_RST] = ctrl_q.hold_reset;
				end
				`RAC_OFF_SQUELCH: begin
					if (rd_dec.ch == 2'h0) rd_word[`RAC_BIT_SQUELCH] = ctrl_q.squelch;
				end
				`RAC_OFF_GAIN_MODE: begin
					if (rd_dec.ch == 2'h0) begin
						rd_word[`RAC_BIT_AUTO_GAIN] = ctrl_q.auto_gain;
						rd_word[`RAC_BIT_SERIAL]    = ctrl_q.serial_source;
					end
				end
				`RAC_OFF_MONITOR: begin
					rd_word[`RAC_BIT_PEAK_DET]  = mon_q[rd_dec.ch].peak_det;
					rd_word[`RAC_BIT_GAIN_VOLT] = mon_q[rd_dec.ch].gain_volt;
				end
				default: begin
					rd_word = 16'h0000; // reserved words and unassigned offsets
				end
			endcase
		end
	end

	// read data is snapshotted when the header completes, then shifted out
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_q <= 16'h0000;
		end else if (hdr_done) begin
			tx_q <= cmd_d.rd ? rd_word : 16'h0000;
		end else if (fall && state_q == rac_pkg::ST_DATA && cmd_q.rd) begin
			tx_q <= {tx_q[14:0], 1'h0};
		end
	end

	// miso is released whenever chip select is high, so other clients may share it
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			spi_miso_o    <= 1'h0;
			spi_miso_oe_n <= 1'h1;
		end else if (csn_f) begin
			spi_miso_o    <= 1'h0;
			spi_miso_oe_n <= 1'h1;
		end else if (fall && state_q == rac_pkg::ST_DATA && cmd_q.rd) begin
			spi_miso_o    <= tx_q[15];
			spi_miso_oe_n <= 1'h0;
		end
	end

	// shared controls: one copy for all channels
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_q.hold_reset    <= `RAC_RST_SOFT_RST;
			ctrl_q.squelch       <= `RAC_RST_SQUELCH;
			ctrl_q.auto_gain     <= `RAC_RST_AUTO_GAIN;
			ctrl_q.serial_source <= `RAC_RST_SERIAL;
		end else begin
			if (wr_shared && wr_dec.off == `RAC_OFF_SOFT_RST) begin
				ctrl_q.hold_reset <= wr_data[`RAC_BIT_SOFT_RST];
			end
			if (ctrl_q.hold_reset) begin
				// held at defaults for as long as the soft reset bit stays set
				ctrl_q.squelch       <= `RAC_RST_SQUELCH;
				ctrl_q.auto_gain     <= `RAC_RST_AUTO_GAIN;
				ctrl_q.serial_source <= `RAC_RST_SERIAL;
			end else if (wr_shared && wr_dec.off == `RAC_OFF_SQUELCH) begin
				ctrl_q.squelch <= wr_data[`RAC_BIT_SQUELCH];
			end else if (wr_shared && wr_dec.off == `RAC_OFF_GAIN_MODE) begin
				ctrl_q.auto_gain     <= wr_data[`RAC_BIT_AUTO_GAIN];
				ctrl_q.serial_source <= wr_data[`RAC_BIT_SERIAL];
			end
		end
	end

	// one monitor selection word per channel; a window of 32 words each
	for (genvar k = 0; k < 4; k++) begin : g_mon
		rac_mon_reg u_mon (
			.clk        (clk),
			.reset_n    (reset_n),
			.hold_reset (ctrl_q.hold_reset),
			.wr_en      (wr_fire && wr_dec.ch == 2'(k) && wr_dec.off == `RAC_OFF_MONITOR),
			.wr_val     ({wr_data[`RAC_BIT_PEAK_DET], wr_data[`RAC_BIT_GAIN_VOLT]}),
			.mon_q      (mon_q[k])
		);
	end

	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	a_soft_reset_defaults: assert property (
		ctrl_q.hold_reset |=> (ctrl_q.squelch && !ctrl_q.auto_gain && !ctrl_q.serial_source && mon_q == '0))
		else $error("soft reset did not restore defaults");

	a_squelch_write: assert property (
		(wr_shared && wr_dec.off == `RAC_OFF_SQUELCH && !ctrl_q.hold_reset)
		|=> ctrl_q.squelch == $past(wr_data[`RAC_BIT_SQUELCH]))
		else $error("squelch bit not taken from write");

	a_squelch_sticks: assert property (
		(ctrl_q.squelch && !(wr_shared && wr_dec.off == `RAC_OFF_SQUELCH)) |=> ctrl_q.squelch)
		else $error("squelch cleared without a write");

	a_gain_mode_write: assert property (
		(wr_shared && wr_dec.off == `RAC_OFF_GAIN_MODE && !ctrl_q.hold_reset)
		|=> (ctrl_q.auto_gain == $past(wr_data[0]) && ctrl_q.serial_source == $past(wr_data[1])))
		else $error("gain mode bits not taken from write");

	a_shared_ch_ignore: assert property (
		(wr_fire && wr_dec.ch != 2'h0 && !ctrl_q.hold_reset) |=> $stable(ctrl_q))
		else $error("shared control changed by a non-zero channel write");

	a_id_only_ch0: assert property (
		(hdr_done && rd_dec.ch != 2'h0 && rd_dec.off <= `RAC_OFF_GAIN_MODE) |=> tx_q == 16'h0000)
		else $error("shared word answered outside channel zero");

	a_maker_id_read: assert property (
		(hdr_done && cmd_d.rd && rd_dec.hit && rd_dec.ch == 2'h0 && rd_dec.off == `RAC_OFF_MAKER)
		|=> tx_q == MAKER_ID)
		else $error("maker identifier not loaded for read");

	a_reserved_zero: assert property (
		(hdr_done && (rd_dec.off == `RAC_OFF_RSVD_A || rd_dec.off == `RAC_OFF_RSVD_B || !rd_dec.hit))
		|=> tx_q == 16'h0000)
		else $error("reserved or unmapped word read non-zero");

	a_monitor_write: assert property (
		(wr_fire && wr_dec.off == `RAC_OFF_MONITOR && !ctrl_q.hold_reset)
		|=> mon_q[$past(wr_dec.ch)] == {$past(wr_data[10]), $past(wr_data[9])})
		else $error("monitor selection not taken from write");

	a_miso_released: assert property (
		csn_f |=> spi_miso_oe_n ##1 spi_miso_oe_n)
		else $error("miso driven while deselected");

	a_miso_data_bit: assert property (
		(fall && state_q == rac_pkg::ST_DATA && cmd_q.rd)
		|=> (!spi_miso_oe_n && spi_miso_o == $past(tx_q[15])))
		else $error("miso bit not taken from the read word");

	a_soft_reset_holds: assert property (
		(ctrl_q.hold_reset && !(wr_shared && wr_dec.off == `RAC_OFF_SOFT_RST)) |=> ctrl_q.hold_reset)
		else $error("soft reset bit cleared without a write");

	a_gain_mode_read: assert property (
		(hdr_done && cmd_d.rd && rd_dec.hit && rd_dec.ch == 2'h0 && rd_dec.off == `RAC_OFF_GAIN_MODE)
		|=> tx_q == {14'h0000, $past(ctrl_q.serial_source), $past(ctrl_q.auto_gain)})
		else $error("gain mode word not loaded for read");

	c_write_frame: cover property (wr_fire);
	c_read_frame: cover property (hdr_done && cmd_d.rd ##[1:1000] csn_f);
	c_soft_reset: cover property ($rose(ctrl_q.hold_reset));
	c_unsquelch: cover property ($fell(ctrl_q.squelch));

endmodule : rac_ctrl_regs

// ---- rac_spi_host.sv ----
// serial host model that frames commands to the amplifier control bank
`timescale 1ns/1ps
module rac_spi_host (
	// clock
	input  wire logic clk,
	// serial pins
	output logic      sclk,
	output logic      csn,
	output logic      mosi,
	input  wire logic miso
);
	initial begin
		sclk = 1'h0;
		csn  = 1'h1;
		mosi = 1'h0;
	end

	// nbits below 33 cuts the frame short; low phase 7 clk, high 5 clk gives the 48 ns period
	task automatic xfer(input logic [14:0] addr, input logic rd, input logic wr, input logic [15:0] wdata,
		input int nbits, output logic [15:0] rdata);
		logic [32:0] frame;
		frame = {addr, rd, wr, wdata};
		rdata = 16'h0000;
		@(posedge clk) csn <= 1'h0;
		repeat (13) @(posedge clk);
		for (int i = 32; i > 32 - nbits; i--) begin
			mosi <= frame[i]; // msb first, changed on the trailing edge
			repeat (6) @(posedge clk);
			// sample late in the low phase, the device answers some clocks after the fall
			@(negedge clk);
			if (i < 16) rdata[i] = miso;
			@(posedge clk) sclk <= 1'h1;
			repeat (5) @(posedge clk);
			sclk <= 1'h0;
		end
		repeat (13) @(posedge clk);
		csn  <= 1'h1;
		mosi <= ~mosi;
		// inactive time just above five serial periods
		repeat (64) @(posedge clk);
	endtask : xfer
endmodule : rac_spi_host

// ---- tb_top.sv ----
// self-checking bench of the amplifier control bank driven by a serial host model
`timescale 1ns/1ps
module tb_top;
	localparam logic [15:0] MAKER = 16'hC3A1; // arbitrary value
	localparam logic [15:0] PART  = 16'h7E02; // arbitrary value
	localparam logic [15:0] DATE  = 16'h0B19; // arbitrary value

	logic                      clk;
	logic                      reset_n;
	logic                      sclk;
	logic                      csn;
	logic                      mosi;
	logic                      miso_o;
	logic                      miso_oe_n;
	logic                      miso_last;
	wire                       miso_wire;
	rac_pkg::rac_ctrl_type     ctrl_q;
	rac_pkg::rac_mon_type [3:0] mon_q;
	logic [15:0]               rdq;
	logic [7:0]                mon_exp;
	int                        fail_count;
	int                        n_checks;

	rac_ctrl_regs #(.MAKER_ID(MAKER), .PART_ID(PART), .DATE_REV(DATE)) i_dut (
		.clk           (clk),
		.reset_n       (reset_n),
		.spi_clk_pin   (sclk),
		.spi_csn_pin   (csn),
		.spi_mosi_pin  (mosi),
		.spi_miso_o    (miso_o),
		.spi_miso_oe_n (miso_oe_n),
		.ctrl_q        (ctrl_q),
		.mon_q         (mon_q)
	);

	rac_spi_host i_host (
		.clk  (clk),
		.sclk (sclk),
		.csn  (csn),
		.mosi (mosi),
		.miso (miso_wire)
	);

	// a released line has no pull, so show the inverse of its last driven value
	always @(posedge clk) if (!miso_oe_n) miso_last <= miso_o;
	assign miso_wire = miso_oe_n ? ~miso_last : miso_o;

	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end

	function automatic logic [14:0] adr(input int ch, input logic [4:0] off);
		logic [1:0] c;
		c = ch[1:0];
		return {6'h00, c, 2'h0, off};
	endfunction : adr

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			$display("wrong value %s expected %h seen %h", name, exp, seen);
			fail_count++;
		end
	endtask : check

	task automatic wr(input int ch, input logic [4:0] off, input logic [15:0] d);
		logic [15:0] q;
		i_host.xfer(adr(ch, off), 1'h0, 1'h1, d, 33, q);
	endtask : wr

	task automatic rchk(input int ch, input logic [4:0] off, input logic [15:0] exp);
		logic [15:0] q;
		i_host.xfer(adr(ch, off), 1'h1, 1'h0, 16'hA5A5, 33, q);
		check("read word", q, exp);
		check("miso release", {15'h0000, miso_oe_n}, 16'h0001);
	endtask : rchk

	task automatic ck_ctrl(input logic [3:0] exp);
		check("ctrl", {12'h000, ctrl_q}, {12'h000, exp});
	endtask : ck_ctrl

	task automatic t_reset;
		ck_ctrl(4'h4);
		check("mon", {8'h00, mon_q}, 16'h0000);
		rchk(0, 5'h05, 16'h0000);
		rchk(0, 5'h06, 16'h0001);
		rchk(0, 5'h07, 16'h0000);
		rchk(0, 5'h00, MAKER);
		rchk(0, 5'h01, 16'h0000);
		rchk(0, 5'h02, PART);
		rchk(0, 5'h03, 16'h0000);
		rchk(0, 5'h04, DATE);
	endtask : t_reset

	task automatic t_shared;
		for (int ch = 1; ch < 4; ch++)
			for (int off = 0; off < 8; off++)
				rchk(ch, off[4:0], 16'h0000);
		wr(1, 5'h06, 16'h0000);
		ck_ctrl(4'h4);
		wr(2, 5'h05, 16'h0001);
		wr(3, 5'h07, 16'h0003);
		ck_ctrl(4'h4);
	endtask : t_shared

	task automatic t_ctrl;
		wr(0, 5'h06, 16'h0000);
		ck_ctrl(4'h0);
		wr(0, 5'h07, 16'hFFFF);
		ck_ctrl(4'h3);
		rchk(0, 5'h07, 16'h0003);
		wr(0, 5'h07, 16'h0001);
		ck_ctrl(4'h2);
		wr(0, 5'h07, 16'h0002);
		ck_ctrl(4'h1);
		wr(0, 5'h07, 16'h0000);
		ck_ctrl(4'h0);
	endtask : t_ctrl

	task automatic t_mon;
		mon_exp = 8'h00;
		for (int k = 0; k < 4; k++) begin
			// only one source bit per word, undefined bits set in the even-channel words to show they are dropped
			wr(k, 5'h08, k[0] ? 16'h0400 : 16'hFBFF);
			mon_exp[2*k +: 2] = k[0] ? 2'h2 : 2'h1;
			check("mon", {8'h00, mon_q}, {8'h00, mon_exp});
			rchk(k, 5'h08, k[0] ? 16'h0400 : 16'h0200);
			wr(k, 5'h1F, 16'hFFFF);
			rchk(k, 5'h1F, 16'h0000);
		end
		i_host.xfer(15'h0020, 1'h1, 1'h0, 16'h0000, 33, rdq);
		check("gap word", rdq, 16'h0000);
	endtask : t_mon

	task automatic t_refuse;
		i_host.xfer(adr(0, 5'h08), 1'h1, 1'h1, 16'h0400, 33, rdq);
		check("mon", {8'h00, mon_q}, {8'h00, mon_exp});
		i_host.xfer(adr(0, 5'h08), 1'h0, 1'h1, 16'h0400, 32, rdq);
		check("mon", {8'h00, mon_q}, {8'h00, mon_exp});
	endtask : t_refuse

	task automatic t_soft;
		wr(0, 5'h05, 16'h0001);
		ck_ctrl(4'hC);
		check("mon", {8'h00, mon_q}, 16'h0000);
		wr(0, 5'h06, 16'h0000);
		ck_ctrl(4'hC);
		rchk(0, 5'h05, 16'h0001);
		wr(0, 5'h05, 16'h0000);
		ck_ctrl(4'h4);
	endtask : t_soft

	task automatic t_hwreset;
		wr(0, 5'h06, 16'h0000);
		wr(2, 5'h08, 16'h0200);
		ck_ctrl(4'h0);
		check("mon", {8'h00, mon_q}, 16'h0010);
		@(posedge clk) reset_n <= 1'h0;
		repeat (3) @(posedge clk);
		ck_ctrl(4'h4);
		check("mon", {8'h00, mon_q}, 16'h0000);
		reset_n <= 1'h1;
		repeat (8) @(posedge clk);
		rchk(0, 5'h06, 16'h0001);
	endtask : t_hwreset

	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_sim

	initial begin
		#200000;
		fail_count++;
		end_sim();
	end

	initial begin
		fail_count = 0;
		n_checks   = 0;
		miso_last  = 1'h0;
		reset_n    = 1'h0;
		repeat (20) @(posedge clk);
		reset_n <= 1'h1;
		repeat (8) @(posedge clk);
		t_reset();
		t_shared();
		t_ctrl();
		t_mon();
		t_refuse();
		t_soft();
		t_hwreset();
		end_sim();
	end
endmodule : tb_top
